/* include/sysconf_pkg.sv */
// Package: register map, field positions, reset values and timing counts
package sysconf_pkg;
  // Register byte addresses (no offsets printed; chosen here)
  localparam logic [11:0] ADDR_OPTIONS   = 12'h000;
  localparam logic [11:0] ADDR_CLKOUT    = 12'h004;
  localparam logic [11:0] ADDR_ID_HIGH   = 12'h008;
  localparam logic [11:0] ADDR_ID_LOW    = 12'h00c;
  localparam logic [11:0] ADDR_WAKEUP    = 12'h010;
  localparam logic [11:0] ADDR_RESET_CAUSE = 12'h014;

  // Options fields
  localparam int OPT_WDOG_EN    = 7;
  localparam int OPT_WDOG_LONG  = 6;
  localparam int OPT_STOP_ALLOW = 5;
  localparam logic [7:0] OPT_RESET = 8'hc0;
  localparam logic [7:0] OPT_MASK  = 8'hf3;

  // Clock output fields
  localparam int CLK_PIN_EN = 4;
  localparam logic [7:0] CLK_MASK = 8'h17;

  // Wakeup control fields
  localparam int WK_FLAG = 7;
  localparam int WK_ACK  = 6;
  localparam int WK_CSEL = 5;
  localparam int WK_IE   = 4;
  localparam logic [7:0] WK_MASK = 8'h37;

  // Part number, arbitrary value
  localparam logic [11:0] PART_NUMBER = 12'h5a3;
  localparam logic [3:0]  ID_RSVD     = 4'h0;

  // Watchdog periods in bus clocks
  localparam logic [17:0] WDOG_SHORT = 18'h01fff;
  localparam logic [17:0] WDOG_LONG  = 18'h3ffff;

  // Internal oscillator frequency and 1 ms tick derivation
  localparam int CLK_HZ        = 50_000_000;
  localparam int WAKE_TICK_US  = 1000;
  localparam int WAKE_TICK_CYC = CLK_HZ / 1_000_000 * WAKE_TICK_US;
endpackage

/* src/sysconf.sv */
// System configuration registers with watchdog, clock output and wakeup timer
// Contract
// - Options register honours only first write
// - Options bits 3 and 2 read zero
// - Bit 7 enables watchdog reset, resets one
// - Bit 6 picks 2^13 or 2^18 cycles
// - Stop without permission forces illegal-opcode reset
// - Clock-output bit 4 enables pin drive
// - Output frequency is bus over twice field
// - Zero divide with enable drives pin low
// - Read-only 12-bit part number in two bytes
// - High id bits 7:4 reserved, writes ignored
// - Wakeup flag set on timer timeout
// - Writing one to ack clears flag
// - Bit 5 selects internal or external clock
// - Bit 4 enables wakeup interrupt request
// - Delay code zero disables wakeup timer
// - Internal codes give 8ms to 1.024s
// - External codes divide by 256 to 32768
// - Unused wakeup bits read zero
// - Reset-cause write clears watchdog counter
//
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module sysconf #(
  parameter int WAKE_TICK = sysconf_pkg::WAKE_TICK_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [31:0] prdata,
  input  wire logic        stop_request,
  input  wire logic        ext_clk_tick,
  output logic             watchdog_reset_req,
  output logic             illegal_op_reset_req,
  output logic             clkout,
  output logic             clkout_oe,
  output logic             wakeup_irq
);

  logic [7:0]  options_q;
  logic        options_locked_q;
  logic [7:0]  clkctl_q;
  logic [7:0]  wakectl_q;
  logic        wake_flag_q;
  logic [17:0] wdog_cnt_q;
  logic [2:0]  div_cnt_q;
  logic        clkout_q;
  logic [15:0] tick_cnt_q;
  logic [14:0] wake_cnt_q;
  logic [14:0] wake_limit;
  logic        wake_tick;
  logic        wake_expire;
  logic        wr_en;
  logic        rd_en;
  logic [7:0]  rd_byte;
  logic        addr_ok;
  logic [2:0]  dsel;

  // Decodes one mapped register address
  function automatic logic is_reg(input logic [11:0] a,
                                  input logic [11:0] r);
    return a == r;
  endfunction

  // Zero-wait slave; unmapped addresses get pslverr
  assign pready = 1'b1;
  assign wr_en  = psel && penable && pwrite;
  assign rd_en  = psel && penable && !pwrite;
  assign addr_ok = is_reg(paddr, sysconf_pkg::ADDR_OPTIONS)
                 || is_reg(paddr, sysconf_pkg::ADDR_CLKOUT)
                 || is_reg(paddr, sysconf_pkg::ADDR_ID_HIGH)
                 || is_reg(paddr, sysconf_pkg::ADDR_ID_LOW)
                 || is_reg(paddr, sysconf_pkg::ADDR_WAKEUP)
                 || is_reg(paddr, sysconf_pkg::ADDR_RESET_CAUSE);
  assign pslverr = psel && penable && !addr_ok;

  always_comb begin
    rd_byte = 8'h00;
    if (is_reg(paddr, sysconf_pkg::ADDR_OPTIONS))
      rd_byte = options_q & sysconf_pkg::OPT_MASK;
    else if (is_reg(paddr, sysconf_pkg::ADDR_CLKOUT))
      rd_byte = clkctl_q & sysconf_pkg::CLK_MASK;
    else if (is_reg(paddr, sysconf_pkg::ADDR_ID_HIGH))
      rd_byte = {sysconf_pkg::ID_RSVD,
                 sysconf_pkg::PART_NUMBER[11:8]};
    else if (is_reg(paddr, sysconf_pkg::ADDR_ID_LOW))
      rd_byte = sysconf_pkg::PART_NUMBER[7:0];
    else if (is_reg(paddr, sysconf_pkg::ADDR_WAKEUP))
      rd_byte = {wake_flag_q, 1'b0, wakectl_q[5:4], 1'b0,
                 wakectl_q[2:0]};
  end

  // Read data registered at the setup edge, held until next read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= {24'h00_0000, rd_byte};
    end
  end

  // Write-once options; lock taken by the first write of any value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      options_q        <= sysconf_pkg::OPT_RESET;
      options_locked_q <= 1'b0;
    end else if (wr_en && is_reg(paddr, sysconf_pkg::ADDR_OPTIONS)
                 && !options_locked_q) begin
      options_q        <= pwdata[7:0] & sysconf_pkg::OPT_MASK;
      options_locked_q <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clkctl_q <= 8'h00;
    end else if (wr_en && is_reg(paddr, sysconf_pkg::ADDR_CLKOUT)) begin
      clkctl_q <= pwdata[7:0] & sysconf_pkg::CLK_MASK;
    end
  end

  // Watchdog: kicked by any write to the reset-cause address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdog_cnt_q         <= 18'h00000;
      watchdog_reset_req <= 1'b0;
    end else if (!options_q[sysconf_pkg::OPT_WDOG_EN]) begin
      wdog_cnt_q         <= 18'h00000;
      watchdog_reset_req <= 1'b0;
    end else if (wr_en
                 && is_reg(paddr, sysconf_pkg::ADDR_RESET_CAUSE)) begin
      wdog_cnt_q         <= 18'h00000;
      watchdog_reset_req <= 1'b0;
    end else if (wdog_cnt_q == (options_q[sysconf_pkg::OPT_WDOG_LONG]
                 ? sysconf_pkg::WDOG_LONG : sysconf_pkg::WDOG_SHORT)) begin
      wdog_cnt_q         <= 18'h00000;
      watchdog_reset_req <= 1'b1;
    end else begin
      wdog_cnt_q         <= wdog_cnt_q + 18'h00001;
      watchdog_reset_req <= 1'b0;
    end
  end

  // Stop while not allowed becomes an illegal-opcode reset request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      illegal_op_reset_req <= 1'b0;
    end else begin
      illegal_op_reset_req <= stop_request
        && !options_q[sysconf_pkg::OPT_STOP_ALLOW];
    end
  end

  // Clock output: toggle every N bus clocks gives bus/(2N)
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_q <= 3'h0;
      clkout_q  <= 1'b0;
    end else if (!clkctl_q[sysconf_pkg::CLK_PIN_EN]
                 || clkctl_q[2:0] == 3'h0) begin
      div_cnt_q <= 3'h0;
      clkout_q  <= 1'b0;
    end else if (div_cnt_q >= clkctl_q[2:0] - 3'h1) begin
      div_cnt_q <= 3'h0;
      clkout_q  <= !clkout_q;
    end else begin
      div_cnt_q <= div_cnt_q + 3'h1;
    end
  end
  assign clkout    = clkout_q;
  assign clkout_oe = clkctl_q[sysconf_pkg::CLK_PIN_EN];

  // 1 ms tick stands in for the free-running internal oscillator
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_q <= 16'h0000;
    end else if (tick_cnt_q == 16'(WAKE_TICK - 1)) begin
      tick_cnt_q <= 16'h0000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 16'h0001;
    end
  end

  assign dsel = wakectl_q[2:0];
  assign wake_tick = wakectl_q[sysconf_pkg::WK_CSEL] ? ext_clk_tick
                   : (tick_cnt_q == 16'(WAKE_TICK - 1));

  always_comb begin
    wake_limit = 15'h0000;
    if (wakectl_q[sysconf_pkg::WK_CSEL]) begin
      case (dsel)
        3'h1:    wake_limit = 15'h00ff;
        3'h2:    wake_limit = 15'h03ff;
        3'h3:    wake_limit = 15'h07ff;
        3'h4:    wake_limit = 15'h0fff;
        3'h5:    wake_limit = 15'h1fff;
        3'h6:    wake_limit = 15'h3fff;
        3'h7:    wake_limit = 15'h7fff;
        default: wake_limit = 15'h0000;
      endcase
    end else begin
      case (dsel)
        3'h1:    wake_limit = 15'h0007;
        3'h2:    wake_limit = 15'h001f;
        3'h3:    wake_limit = 15'h003f;
        3'h4:    wake_limit = 15'h007f;
        3'h5:    wake_limit = 15'h00ff;
        3'h6:    wake_limit = 15'h01ff;
        3'h7:    wake_limit = 15'h03ff;
        default: wake_limit = 15'h0000;
      endcase
    end
  end

  assign wake_expire = (dsel != 3'h0) && wake_tick
                     && (wake_cnt_q >= wake_limit);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_cnt_q <= 15'h0000;
    end else if (dsel == 3'h0) begin
      wake_cnt_q <= 15'h0000;
    end else if (wake_tick) begin
      wake_cnt_q <= wake_expire ? 15'h0000 : wake_cnt_q + 15'h0001;
    end
  end

  // Control bits; ack is not stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wakectl_q <= 8'h00;
    end else if (wr_en && is_reg(paddr, sysconf_pkg::ADDR_WAKEUP)) begin
      wakectl_q <= pwdata[7:0] & sysconf_pkg::WK_MASK;
    end
  end

  // Set wins over a same-cycle acknowledge so no timeout is lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_flag_q <= 1'b0;
    end else if (wake_expire) begin
      wake_flag_q <= 1'b1;
    end else if (wr_en && is_reg(paddr, sysconf_pkg::ADDR_WAKEUP)
                 && pwdata[sysconf_pkg::WK_ACK]) begin
      wake_flag_q <= 1'b0;
    end
  end

  assign wakeup_irq = wake_flag_q
                    && wakectl_q[sysconf_pkg::WK_IE];

endmodule

/* bench/sysconf_assertions.sv */
// Checker for bus answers and output relations of sysconf
`timescale 1ns/1ps
module sysconf_assertions (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  input wire logic        stop_request,
  input wire logic        watchdog_reset_req,
  input wire logic        illegal_op_reset_req,
  input wire logic        clkout,
  input wire logic        clkout_oe,
  input wire logic        wakeup_irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  logic rd;
  assign acc = psel && penable;
  assign rd  = acc && !pwrite;
  AST_READY: assert property (acc |-> pready)
    else $error("no ready in access");
  AST_UNMAPPED: assert property (acc && paddr == 12'h018 |-> pslverr)
    else $error("no error on unmapped");
  AST_OPT_ZERO: assert property (
    rd && paddr == sysconf_pkg::ADDR_OPTIONS |-> prdata[3:2] == 2'b00)
    else $error("options bits 3:2 not zero");
  AST_ID_HIGH: assert property (
    rd && paddr == sysconf_pkg::ADDR_ID_HIGH
    |-> prdata == {28'h0, sysconf_pkg::PART_NUMBER[11:8]})
    else $error("id high wrong");
  AST_ID_LOW: assert property (
    rd && paddr == sysconf_pkg::ADDR_ID_LOW
    |-> prdata == {24'h0, sysconf_pkg::PART_NUMBER[7:0]})
    else $error("id low wrong");
  AST_WK_ZERO: assert property (
    rd && paddr == sysconf_pkg::ADDR_WAKEUP
    |-> prdata[6] == 1'b0 && prdata[3] == 1'b0 && prdata[31:8] == 24'h0)
    else $error("wakeup fixed bits not zero");
  AST_IRQ_OFF: assert property (
    acc && pwrite && paddr == sysconf_pkg::ADDR_WAKEUP && !pwdata[4]
    |=> !wakeup_irq)
    else $error("irq with enable clear");
  AST_ILOP: assert property (
    $rose(illegal_op_reset_req) |-> $past(stop_request))
    else $error("illegal reset without stop");
  AST_CLK_OFF: assert property (!clkout_oe [*2] |-> !clkout)
    else $error("clock out while disabled");
  AST_WDOG_PULSE: assert property (
    watchdog_reset_req |=> !watchdog_reset_req)
    else $error("watchdog pulse too long");
  cover property (acc && pslverr);
  cover property ($rose(wakeup_irq));
  cover property ($rose(watchdog_reset_req));
endmodule
bind sysconf sysconf_assertions chk_i (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
  .stop_request(stop_request), .watchdog_reset_req(watchdog_reset_req),
  .illegal_op_reset_req(illegal_op_reset_req), .clkout(clkout),
  .clkout_oe(clkout_oe), .wakeup_irq(wakeup_irq));

/* bench/system_config_and_periodic_wakeup_test.sv */
// Self-checking bench for the system configuration block
`timescale 1ns/1ps
module system_config_and_periodic_wakeup_test;
  localparam int T = 4;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic        stop_request = 0, ext_clk_tick = 0, ext_on = 0, e, x;
  logic        pready, pslverr, watchdog_reset_req, illegal_op_reset_req;
  logic        clkout, clkout_oe, wakeup_irq;
  logic [7:0]  r, v;
  logic [2:0]  c;
  int          n_mismatch = 0, cmp_count = 0, cyc = 0, n, m;
  sysconf #(.WAKE_TICK(T)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .stop_request(stop_request), .ext_clk_tick(ext_clk_tick),
    .watchdog_reset_req(watchdog_reset_req),
    .illegal_op_reset_req(illegal_op_reset_req), .clkout(clkout),
    .clkout_oe(clkout_oe), .wakeup_irq(wakeup_irq));
  initial begin
    forever #10 pclk = ~pclk;
  end
  // Random ticks while internal source runs, so the select is exercised
  always @(posedge pclk) ext_clk_tick <= ext_on | 1'($urandom_range(1));
  always @(posedge pclk) begin
    cyc++;
    // Ceiling sized for the longest wakeup and watchdog waits
    if (cyc == 95000) begin
      n_mismatch++;
      test_done();
    end
  end
  task automatic test_done();
    if (n_mismatch == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] g, input logic [31:0] q);
    cmp_count++;
    if (g !== q) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h got %h", s, q, g);
    end
  endtask
  task automatic rst();
    presetn <= 0;
    repeat (6) @(posedge pclk);
    presetn <= 1;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata[7:0];
    e = pslverr;
    psel <= 0;
    penable <= 0;
    // Idle edge so the next call never rewrites psel in this step
    @(posedge pclk);
  endtask
  task automatic rd8(input logic [11:0] a, input logic [7:0] q, input string s);
    apb(0, a, 8'h00);
    chk(s, r, q);
  endtask
  // Cycles between two rising edges of the divided clock, 0 if none
  task automatic per();
    int  t0;
    logic p;
    t0 = -1;
    n = 0;
    p = clkout;
    for (int i = 0; i < 60; i++) begin
      @(negedge pclk);
      if (clkout && !p) begin
        if (t0 >= 0 && n == 0) n = i - t0;
        t0 = i;
      end
      p = clkout;
    end
    @(posedge pclk);
  endtask
  task automatic wsig(input bit w);
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while ((w ? watchdog_reset_req : wakeup_irq) !== 1'b1 && n < 40000);
    @(posedge pclk);
  endtask
  function automatic int wcnt(input logic [2:0] k, input logic xs);
    return (xs ? 1 : T) << (((k == 1) ? 0 : int'(k)) + (xs ? 8 : 3));
  endfunction
  initial begin
    v = $urandom(71);
    rst();
    rd8(sysconf_pkg::ADDR_OPTIONS, 8'hc0, "opt_rst");
    rd8(sysconf_pkg::ADDR_CLKOUT, 8'h00, "clk_rst");
    apb(1, sysconf_pkg::ADDR_ID_HIGH, 8'hff);
    rd8(sysconf_pkg::ADDR_ID_HIGH, sysconf_pkg::PART_NUMBER[11:8], "idh");
    rd8(sysconf_pkg::ADDR_ID_LOW, sysconf_pkg::PART_NUMBER[7:0], "idl");
    rd8(sysconf_pkg::ADDR_WAKEUP, 8'h00, "wk_rst");
    apb(0, 12'h018, 8'h00);
    chk("slverr", e, 1);
    v[7] = 0;
    v[5] = 0;
    apb(1, sysconf_pkg::ADDR_OPTIONS, v);
    apb(1, sysconf_pkg::ADDR_OPTIONS, ~v);
    rd8(sysconf_pkg::ADDR_OPTIONS, v & 8'hf3, "opt_once");
    stop_request <= 1;
    repeat (3) @(posedge pclk);
    chk("ilop", illegal_op_reset_req, 1);
    for (int d = 0; d < 8; d++) begin
      apb(1, sysconf_pkg::ADDR_CLKOUT, 8'h10 | d);
      rd8(sysconf_pkg::ADDR_CLKOUT, 8'h10 | d, "clk_rw");
      per();
      chk("clk_per", n, d * 2);
      chk("clk_oe", clkout_oe, 1);
      if (d == 0) chk("clk_low", clkout, 0);
    end
    apb(1, sysconf_pkg::ADDR_CLKOUT, 8'h05);
    repeat (3) @(posedge pclk);
    chk("clk_dis", {clkout_oe, clkout}, 0);
    for (int k = 0; k < 14; k++) begin
      c = 3'(k % 7 + 1);
      x = k > 6;
      apb(1, sysconf_pkg::ADDR_WAKEUP, 8'h40);
      ext_on <= x;
      apb(1, sysconf_pkg::ADDR_WAKEUP, {2'b00, x, 2'b10, c});
      wsig(0);
      m = wcnt(c, x);
      chk("wk_time", n >= m - T - 2 && n <= m + T + 4, 1);
      rd8(sysconf_pkg::ADDR_WAKEUP, {2'b10, x, 2'b10, c}, "wk_flag");
      apb(1, sysconf_pkg::ADDR_WAKEUP, {2'b01, x, 2'b10, c});
      rd8(sysconf_pkg::ADDR_WAKEUP, {2'b00, x, 2'b10, c}, "wk_ack");
    end
    ext_on <= 0;
    apb(1, sysconf_pkg::ADDR_WAKEUP, 8'h50);
    repeat (300) @(posedge pclk);
    chk("wk_off", wakeup_irq, 0);
    apb(1, sysconf_pkg::ADDR_WAKEUP, 8'h41);
    repeat (200) @(posedge pclk);
    chk("wk_noie", wakeup_irq, 0);
    rd8(sysconf_pkg::ADDR_WAKEUP, 8'h81, "wk_noie_f");
    // Second reset in mid-run rearms the write-once options
    rst();
    apb(1, sysconf_pkg::ADDR_OPTIONS, 8'ha0);
    repeat (3) @(posedge pclk);
    chk("ilop_off", illegal_op_reset_req, 0);
    repeat (6000) @(posedge pclk);
    apb(1, sysconf_pkg::ADDR_RESET_CAUSE, v);
    wsig(1);
    chk("wdog", n >= 8188 && n <= 8196, 1);
    test_done();
  end
endmodule
